/* mta_pkg.sv */
package mta_pkg;
  // ****************
  // Sizes
  // ****************
  localparam int DATA_W  = 24;
  localparam int CHANS   = 4;
  localparam int WIN_MAX = 8;
  localparam int LEN_W   = 3;
  localparam int ADDR_W  = 8;
  // ****************
  // Register map
  // ****************
  localparam logic [ADDR_W-1:0] TRIG_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] FILT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] CMD_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0c;
  localparam int FILT_LEN_LSB = 4;
  localparam int CMD_GET_BIT  = 0;
  // ****************
  // Trigger types
  // ****************
  localparam logic [2:0] TRG_NONE  = 3'h0;
  localparam logic [2:0] TRG_LEVEL = 3'h1;
  localparam logic [2:0] TRG_EDGE  = 3'h2;
  localparam logic [2:0] TRG_GATE  = 3'h3;
  localparam logic [2:0] TRG_SOFT  = 3'h4;
  // ****************
  // Filter types
  // ****************
  localparam logic [2:0] FLT_OFF = 3'h0;
  localparam logic [2:0] FLT_MOV = 3'h1;
  localparam logic [2:0] FLT_AVG = 3'h2;
  localparam logic [2:0] FLT_MED = 3'h3;
  localparam logic [2:0] FLT_DNR = 3'h4;
  // Reset values
  localparam logic [2:0]       TRG_RST = TRG_NONE;
  localparam logic [2:0]       FLT_RST = FLT_OFF;
  localparam logic [LEN_W-1:0] LEN_RST = 3'h0;
  // Noise estimate is an IIR of sample steps, weight 1/8
  localparam int NOISE_SHIFT = 3;
  // ****************
  // Types
  // ****************
  typedef logic [DATA_W-1:0] mta_val_type;
  typedef struct packed {
    logic [CHANS-1:0][DATA_W-1:0] val;
  } mta_frame_type;
  typedef logic [DATA_W-1:0] mta_win_type [WIN_MAX];
endpackage : mta_pkg

/* mta_top.sv */
`timescale 1ns/1ns
// What this block does
// RQ1 - Host command selects trigger type: none, level, edge, gated edge, software.
// RQ2 - Level mode: frames stream at data rate while trigger high, stop when low.
// RQ3 - Edge mode: one frame out per rising trigger edge.
// RQ4 - Edges faster than data rate resend the latest sample frame.
// RQ5 - Source keeps data rate above its highest edge trigger frequency.
// RQ6 - Source holds every trigger pulse at least 5 us.
// RQ7 - Gated mode: each rising edge toggles streaming on or off.
// RQ8 - Software mode: each get-reading command emits exactly one frame.
// RQ9 - Trigger gates only the digital output; analog values always update.
// RQ10 - After reset no trigger is active and frames stream at once.
// RQ11 - Averaging acts before the output and keeps the sample rate.
// RQ12 - After reset the filter is off and samples pass unchanged.
// RQ13 - Moving average: one output per sample, mean of latest N.
// RQ14 - Arithmetic average: one mean per block of N samples.
// RQ15 - Median: middle of the latest N samples after each sample.
// RQ16 - Even N median: mean of the two central sorted samples.
// RQ17 - Noise rejection: forward only changes above a running noise estimate.
// RQ18 - Same filter and window length for every channel.
// RQ19 - Changing filter type or length clears history and block counter.
module mta_top
  import mta_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Acquisition samples
  input  wire logic              smp_valid,
  input  wire mta_frame_type     smp_data,
  output logic                   smp_ready,
  // Trigger pin
  input  wire logic              trig_in,
  // Digital output stream
  output logic                   out_valid,
  input  wire logic              out_ready,
  output mta_frame_type          out_data,
  // Analog path values
  output mta_frame_type          ana_data
);
  // ****************
  // Helpers
  // ****************
  function automatic mta_val_type win_mean(mta_win_type w, logic [3:0] n);
    logic [DATA_W+3:0] sum;
    sum = '0;
    for (int k = 0; k < WIN_MAX; k++) begin
      if (k < n) sum = sum + (DATA_W+4)'(w[k]);
    end
    return DATA_W'(sum / n);
  endfunction : win_mean
  function automatic mta_val_type win_median(mta_win_type w, logic [3:0] n);
    logic [3:0]  rank;
    logic [3:0]  lo;
    logic [3:0]  hi;
    mta_val_type a;
    mta_val_type b;
    lo = (n - 4'h1) >> 1;
    hi = n >> 1;
    a = '0;
    b = '0;
    for (int i = 0; i < WIN_MAX; i++) begin
      rank = '0;
      for (int j = 0; j < WIN_MAX; j++) begin
        if (j < n && (w[j] < w[i] || (w[j] == w[i] && j < i))) rank = rank + 4'h1;
      end
      if (i < n && rank == lo) a = w[i];
      if (i < n && rank == hi) b = w[i];
    end
    return DATA_W'(((DATA_W+1)'(a) + (DATA_W+1)'(b)) >> 1); // [RQ16]
  endfunction : win_median
  function automatic mta_val_type abs_diff(mta_val_type a, mta_val_type b);
    return (a > b) ? a - b : b - a;
  endfunction : abs_diff
  // ****************
  // Declarations
  // ****************
  logic [2:0]       trig_mode_ff;
  logic [2:0]       filt_type_ff;
  logic [LEN_W-1:0] filt_len_ff;
  logic             trig_prev_ff;
  logic             gate_ff;
  logic             pend_ff;
  logic [LEN_W-1:0] fill_ff;
  logic [LEN_W-1:0] blk_ff;
  mta_val_type      hist_ff  [CHANS][WIN_MAX-1];
  mta_val_type      noise_ff [CHANS];
  mta_frame_type    latest_ff;
  mta_frame_type    slot1_ff;
  logic [1:0]       cnt_ff;
  logic [1:0]       nxt_cnt;
  mta_frame_type    filt_frame;
  mta_frame_type    push_data;
  mta_win_type      win;
  logic [3:0]       n_len;
  logic [3:0]       n_eff;
  logic             apb_wr;
  logic             filt_wr;
  logic             get_cmd;
  logic             smp_fire;
  logic             filt_valid;
  logic             rise;
  logic             pass_push;
  logic             pend_push;
  logic             push;
  logic             pop;
  assign apb_wr   = psel && penable && pwrite && pready;
  assign filt_wr  = apb_wr && paddr == FILT_OFS;
  assign get_cmd  = apb_wr && paddr == CMD_OFS && pwdata[CMD_GET_BIT];
  assign smp_fire = smp_valid && smp_ready;
  assign rise     = trig_in && !trig_prev_ff;
  assign n_len    = {1'b0, filt_len_ff} + 4'h1;
  assign n_eff    = ({1'b0, fill_ff} + 4'h1 < n_len) ? {1'b0, fill_ff} + 4'h1 : n_len;
  assign pop      = out_valid && out_ready;
  // ****************
  // APB slave, zero wait
  // ****************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == TRIG_OFS || paddr == FILT_OFS
                 || paddr == CMD_OFS || paddr == STAT_OFS);
      if (psel && !penable && !pwrite) begin
        if (paddr == TRIG_OFS) begin
          prdata <= {29'h0, trig_mode_ff};
        end else if (paddr == FILT_OFS) begin
          prdata <= {25'h0, filt_len_ff, 1'b0, filt_type_ff};
        end else if (paddr == STAT_OFS) begin
          prdata <= {24'h0, fill_ff, gate_ff, pend_ff, 1'b0, cnt_ff};
        end else begin
          prdata <= '0;
        end
      end
    end
  end
  // Configuration
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trig_mode_ff <= TRG_RST; // [RQ10]
      filt_type_ff <= FLT_RST; // [RQ12]
      filt_len_ff  <= LEN_RST;
    end else begin
      if (apb_wr && paddr == TRIG_OFS) trig_mode_ff <= pwdata[2:0]; // [RQ1]
      if (filt_wr) begin
        filt_type_ff <= pwdata[2:0];
        filt_len_ff  <= pwdata[FILT_LEN_LSB +: LEN_W];
      end
    end
  end

  // ****************
  // Filter, shared by all channels
  // ****************
  always_comb begin
    filt_frame = smp_data;
    win        = '{default: '0};
    for (int c = 0; c < CHANS; c++) begin // [RQ18]
      for (int k = 0; k < WIN_MAX; k++) begin
        win[k] = (k == 0) ? smp_data.val[c] : hist_ff[c][(k == 0) ? 0 : k-1];
      end
      case (filt_type_ff)
        FLT_MOV: filt_frame.val[c] = win_mean(win, n_eff); // [RQ13]
        FLT_AVG: filt_frame.val[c] = win_mean(win, n_len); // [RQ14]
        FLT_MED: filt_frame.val[c] = win_median(win, n_eff); // [RQ15]
        FLT_DNR: begin
          if (abs_diff(smp_data.val[c], latest_ff.val[c]) <= noise_ff[c]) begin
            filt_frame.val[c] = latest_ff.val[c]; // [RQ17]
          end
        end
        default: filt_frame.val[c] = smp_data.val[c]; // [RQ12]
      endcase
    end
  end
  // Block decimation only thins the output, never the intake
  assign filt_valid = smp_fire && (filt_type_ff != FLT_AVG || blk_ff == filt_len_ff); // [RQ11]
  // History and block counter
  always_ff @(posedge sys_clk) begin
    if (rst || filt_wr) begin
      fill_ff <= '0; // [RQ19]
      blk_ff  <= '0;
    end else if (smp_fire) begin
      if (fill_ff != LEN_W'(WIN_MAX-1)) fill_ff <= fill_ff + 1'b1;
      blk_ff <= (blk_ff == filt_len_ff) ? '0 : blk_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (smp_fire) begin
      for (int c = 0; c < CHANS; c++) begin
        hist_ff[c][0] <= smp_data.val[c];
        for (int k = 1; k < WIN_MAX-1; k++) hist_ff[c][k] <= hist_ff[c][k-1];
      end
    end
  end
  // Noise tracks the mean step size of the raw signal
  always_ff @(posedge sys_clk) begin
    if (rst || filt_wr) begin
      noise_ff <= '{default: '0}; // [RQ19]
    end else if (smp_fire) begin
      for (int c = 0; c < CHANS; c++) begin
        noise_ff[c] <= noise_ff[c] - (noise_ff[c] >> NOISE_SHIFT)
          + (abs_diff(smp_data.val[c], hist_ff[c][0]) >> NOISE_SHIFT); // [RQ17]
      end
    end
  end
  // Latest filtered frame, kept for edge and software reads
  always_ff @(posedge sys_clk) begin
    if (rst) latest_ff <= '0;
    else if (filt_valid) latest_ff <= filt_frame;
  end
  // Analog path ignores the trigger entirely
  always_ff @(posedge sys_clk) begin
    if (rst) ana_data <= '0;
    else if (smp_fire) ana_data <= smp_data; // [RQ9]
  end

  // ****************
  // Trigger
  // ****************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trig_prev_ff <= 1'b0;
      gate_ff      <= 1'b0;
    end else begin
      trig_prev_ff <= trig_in;
      if (trig_mode_ff != TRG_GATE) gate_ff <= 1'b0;
      else if (rise) gate_ff <= !gate_ff; // [RQ7]
    end
  end

  always_comb begin
    case (trig_mode_ff)
      TRG_NONE:  pass_push = filt_valid; // [RQ10]
      TRG_LEVEL: pass_push = filt_valid && trig_in; // [RQ2]
      TRG_GATE:  pass_push = filt_valid && gate_ff; // [RQ7]
      default:   pass_push = 1'b0;
    endcase
  end

  // Pending single frame; a new request wins over its own clear
  assign pend_push = pend_ff && !pass_push && cnt_ff != 2'd2;
  always_ff @(posedge sys_clk) begin
    if (rst) pend_ff <= 1'b0;
    else if (trig_mode_ff == TRG_EDGE && rise) pend_ff <= 1'b1; // [RQ3]
    else if (trig_mode_ff == TRG_SOFT && get_cmd) pend_ff <= 1'b1; // [RQ8]
    else if (pend_push) pend_ff <= 1'b0;
  end

  // Edge faster than data rate re-reads the unchanged latest frame
  assign push_data = pass_push ? filt_frame : latest_ff; // [RQ4]
  assign push      = pass_push || pend_push;

  // ****************
  // Two-entry output buffer
  // ****************
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) nxt_cnt = cnt_ff + 2'd1;
    else if (pop && !push) nxt_cnt = cnt_ff - 2'd1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff    <= '0;
      out_valid <= 1'b0;
      smp_ready <= 1'b0;
      out_data  <= '0;
      slot1_ff  <= '0;
    end else begin
      cnt_ff    <= nxt_cnt;
      out_valid <= nxt_cnt != 2'd0;
      // Stall the source when no slot would be left
      smp_ready <= nxt_cnt != 2'd2;
      if (pop && push) begin
        if (cnt_ff == 2'd1) out_data <= push_data;
        else begin
          out_data <= slot1_ff;
          slot1_ff <= push_data;
        end
      end else if (pop) out_data <= slot1_ff;
      else if (push) begin
        if (cnt_ff == 2'd0) out_data <= push_data;
        else slot1_ff <= push_data;
      end
    end
  end

  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  reset_cfg_a: assert property ($past(rst) |-> trig_mode_ff == TRG_NONE // [RQ10]
    && filt_type_ff == FLT_OFF)
    else $error("config not cleared by reset");
  mode_sel_a: assert property (apb_wr && paddr == TRIG_OFS // [RQ1]
    |=> trig_mode_ff == $past(pwdata[2:0]))
    else $error("trigger type not taken");
  level_gate_a: assert property (trig_mode_ff == TRG_LEVEL && !trig_in |-> !pass_push) // [RQ2]
    else $error("frame out with level low");
  edge_pend_a: assert property (trig_mode_ff == TRG_EDGE && rise // [RQ3]
    |=> pend_ff || $past(pend_push))
    else $error("edge did not request a frame");
  resend_a: assert property (pend_push |-> push_data == latest_ff) // [RQ4]
    else $error("edge frame not the latest");
  gate_toggle_a: assert property (trig_mode_ff == TRG_GATE && rise // [RQ7]
    |=> gate_ff != $past(gate_ff))
    else $error("gate not toggled");
  soft_once_a: assert property (trig_mode_ff == TRG_SOFT && get_cmd |=> pend_ff) // [RQ8]
    else $error("get command lost");
  analog_upd_a: assert property (smp_fire |=> ana_data == $past(smp_data)) // [RQ9]
    else $error("analog value not updated");
  bypass_a: assert property (filt_type_ff == FLT_OFF && smp_fire // [RQ12]
    |-> filt_frame == smp_data)
    else $error("filter off altered sample");
  avg_rate_a: assert property (filt_type_ff == FLT_AVG && blk_ff != filt_len_ff // [RQ14]
    |-> !filt_valid)
    else $error("average output inside block");
  hist_clear_a: assert property (filt_wr |=> fill_ff == '0 && blk_ff == '0) // [RQ19]
    else $error("history not cleared");
  no_lost_a: assert property (smp_fire |-> cnt_ff != 2'd2) // [RQ11]
    else $error("sample taken into full buffer");
endmodule : mta_top

/* mta_src.sv */
`timescale 1ns/1ns
// ****************
// Sample source model
// ****************
module mta_src
  import mta_pkg::*;
(
  // Clock
  input  wire logic     sys_clk,
  // Sample stream
  output logic          smp_valid,
  output mta_frame_type smp_data,
  input  wire logic     smp_ready
);
  initial begin
    smp_valid = 1'b0;
    smp_data  = '0;
  end
  // Held until taken; released data inverted so a stale frame never looks fresh
  task automatic send(input mta_val_type v);
    @(posedge sys_clk);
    smp_valid <= 1'b1;
    smp_data  <= {CHANS{v}};
    do @(posedge sys_clk); while (smp_ready !== 1'b1);
    smp_valid <= 1'b0;
    smp_data  <= ~{CHANS{v}};
  endtask : send
endmodule : mta_src

/* measurement_trigger_and_averaging_test.sv */
`timescale 1ns/1ns
module measurement_trigger_and_averaging_test
  import mta_pkg::*;
;
  logic              sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              smp_valid, smp_ready, trig_in, out_valid, out_ready, err;
  mta_frame_type     smp_data, out_data, ana_data;
  mta_frame_type     got[$];
  int                mismatches, num_checks, cyc;
  mta_top uut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
    .trig_in(trig_in), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .ana_data(ana_data));
  mta_src src (.sys_clk(sys_clk), .smp_valid(smp_valid), .smp_data(smp_data),
    .smp_ready(smp_ready));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Output monitor and hang guard
  always @(posedge sys_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ****************
  // Shared tasks
  // ****************
  function automatic mta_frame_type frm(input mta_val_type v);
    return {CHANS{v}};
  endfunction : frm
  task automatic check(input string nm, input logic [95:0] exp, input logic [95:0] seen);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic exp_out(input mta_val_type v);
    int n;
    n = 0;
    while (got.size() == 0 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    if (got.size() == 0) check("out_data", frm(v), 'x);
    else check("out_data", frm(v), got.pop_front());
  endtask : exp_out
  task automatic none();
    repeat (12) @(posedge sys_clk);
    check("out_count", 0, got.size());
  endtask : none
  // Pulse held 5 us at 8 ns, then 20 idle cycles; no sample is sent between the two edge-mode pulses
  task automatic pulse();
    @(posedge sys_clk);
    trig_in <= 1'b1;
    repeat (625) @(posedge sys_clk);
    trig_in <= 1'b0;
    repeat (20) @(posedge sys_clk);
  endtask : pulse
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    apb(1'b0, TRIG_OFS, 32'h0);
    check("trig_reg", 32'h0, rd);
    apb(1'b0, FILT_OFS, 32'h0);
    check("filt_reg", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    check("pslverr", 1'b1, err);
    src.send(24'h000007);
    exp_out(24'h000007);
    check("ana_data", frm(24'h000007), ana_data);
  endtask : t_reset
  task automatic t_buffer();
    out_ready <= 1'b0;
    fork
      begin
        src.send(24'h000001);
        src.send(24'h000002);
        src.send(24'h000003);
      end
      begin
        repeat (12) @(posedge sys_clk);
        check("smp_ready", 1'b0, smp_ready);
        apb(1'b0, STAT_OFS, 32'h0);
        check("stat_reg", 32'h62, rd);
        out_ready <= 1'b1;
      end
    join
    exp_out(24'h000001);
    exp_out(24'h000002);
    exp_out(24'h000003);
  endtask : t_buffer
  task automatic t_trig();
    apb(1'b1, TRIG_OFS, {29'h0, TRG_LEVEL});
    src.send(24'h000004);
    none();
    trig_in <= 1'b1;
    src.send(24'h000005);
    exp_out(24'h000005);
    trig_in <= 1'b0;
    src.send(24'h000006);
    none();
    check("ana_data", frm(24'h000006), ana_data);
    apb(1'b1, TRIG_OFS, {29'h0, TRG_EDGE});
    src.send(24'h000008);
    none();
    pulse();
    exp_out(24'h000008);
    pulse();
    exp_out(24'h000008);
    apb(1'b1, TRIG_OFS, {29'h0, TRG_GATE});
    pulse();
    src.send(24'h000009);
    exp_out(24'h000009);
    pulse();
    src.send(24'h00000a);
    none();
    apb(1'b1, TRIG_OFS, {29'h0, TRG_SOFT});
    src.send(24'h00000b);
    none();
    apb(1'b1, CMD_OFS, 32'h1);
    exp_out(24'h00000b);
    none();
    apb(1'b1, TRIG_OFS, {29'h0, TRG_NONE});
  endtask : t_trig
  task automatic t_filt();
    apb(1'b1, FILT_OFS, 32'h11);
    src.send(24'h00000a);
    exp_out(24'h00000a);
    src.send(24'h000014);
    exp_out(24'h00000f);
    src.send(24'h000028);
    exp_out(24'h00001e);
    apb(1'b1, FILT_OFS, 32'h12);
    src.send(24'h000002);
    none();
    src.send(24'h000004);
    exp_out(24'h000003);
    src.send(24'h000006);
    src.send(24'h000008);
    exp_out(24'h000007);
    apb(1'b1, FILT_OFS, 32'h33);
    src.send(24'h000001);
    exp_out(24'h000001);
    src.send(24'h000007);
    exp_out(24'h000004);
    src.send(24'h000003);
    exp_out(24'h000003);
    src.send(24'h000064);
    exp_out(24'h000005);
    apb(1'b1, FILT_OFS, 32'h04);
    src.send(24'h000032);
    exp_out(24'h000032);
    src.send(24'h000034);
    exp_out(24'h000032);
    src.send(24'h000080);
    exp_out(24'h000080);
    apb(1'b1, FILT_OFS, 32'h0);
  endtask : t_filt
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    rst       = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = '0;
    trig_in   = 1'b0;
    out_ready = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_buffer();
    t_trig();
    t_filt();
    tally_and_finish();
  end
endmodule : measurement_trigger_and_averaging_test
